// ==== verilog/scpt_slave.sv ====
// Two-wire control port slave: address match, pointer, byte transfer.
// Assumes an external register file written via wr and read via rd_addr,
// returning rd_data combinationally from rd_addr.
`timescale 1ns/1ps
`default_nettype none
module scpt_slave
(
   input  wire logic                core_clk,
   input  wire logic                reset,
   input  wire logic                scl_in,
   input  wire logic                sda_in,
   output var  logic                sda_out,
   output var  logic                sda_oe,
   input  wire logic                addr_select_pin,
   output var  scpt_pkg::scpt_wr_t  wr,
   output var  logic [7:0]          rd_addr,
   input  wire logic [7:0]          rd_data,
   output var  logic                busy
);
   import scpt_pkg::*;

   typedef enum logic [5:0]
   {
      S_IDLE  = 6'b000001,
      S_ADDR  = 6'b000010,
      S_REG   = 6'b000100,
      S_WDATA = 6'b001000,
      S_RDATA = 6'b010000,
      S_WAIT  = 6'b100000
   } scpt_state_t;

   logic        scl_s;
   logic        sda_s;
   logic        sel_s;
   scpt_ev_t    ev;
   scpt_state_t state_reg;
   logic [3:0]  cnt_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  ptr_reg;
   logic [7:0]  tx_reg;
   logic        ack_reg;
   logic        mack_reg;
   logic        rd_reg;
   logic [7:0]  rx_byte;

   scpt_sync u_sync_scl
   (
      .core_clk (core_clk),
      .reset    (reset),
      .din      (scl_in),
      .dout     (scl_s)
   );

   scpt_sync u_sync_sda
   (
      .core_clk (core_clk),
      .reset    (reset),
      .din      (sda_in),
      .dout     (sda_s)
   );

   scpt_sync u_sync_sel
   (
      .core_clk (core_clk),
      .reset    (reset),
      .din      (addr_select_pin),
      .dout     (sel_s)
   );

   scpt_cond u_cond
   (
      .core_clk (core_clk),
      .reset    (reset),
      .scl_s    (scl_s),
      .sda_s    (sda_s),
      .ev       (ev)
   );

   // Byte complete once the eighth bit has been sampled
   assign rx_byte = shift_reg;

   // Bit counter: 0..7 data bits, 8 is the acknowledge slot
   always_ff @(posedge core_clk)
   begin
      if (reset || ev.stop)
         cnt_reg <= SCPT_CNT_RESET;                       // [R15]
      else if (ev.start)
         cnt_reg <= SCPT_CNT_START;                       // [R12] [R15]
      else if (ev.fall)
      begin
         if (cnt_reg == SCPT_ACK_BIT)
            cnt_reg <= SCPT_CNT_RESET;
         else
            cnt_reg <= cnt_reg + 4'h1;
      end
   end

   // Receive shifter, first bit lands in bit 7
   always_ff @(posedge core_clk)
   begin
      if (reset || ev.start || ev.stop)
         shift_reg <= 8'h00;                              // [R15]
      else if (ev.rise && cnt_reg < SCPT_ACK_BIT)
         shift_reg <= {shift_reg[6:0], sda_s};            // [R1]
   end

   // Master acknowledge sampled in the ninth slot of a read byte
   always_ff @(posedge core_clk)
   begin
      if (reset)
         mack_reg <= 1'b0;
      else if (ev.rise && cnt_reg == SCPT_ACK_BIT)
         mack_reg <= ~sda_s;
   end

   // Control state machine
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_reg <= S_IDLE;
         ack_reg   <= 1'b0;
         rd_reg    <= 1'b0;
      end
      else if (ev.stop)
      begin
         state_reg <= S_IDLE;                             // [R11]
         ack_reg   <= 1'b0;
      end
      else if (ev.start)
      begin
         state_reg <= S_ADDR;                             // [R12]
         ack_reg   <= 1'b0;
      end
      else if (ev.fall && cnt_reg == 4'h7)
      begin
         // Decide the acknowledge as the ninth pulse begins
         case (state_reg)
            S_ADDR:
            begin
               ack_reg <= (rx_byte[7:1] == {SCPT_ADDR_HI, sel_s}); // [R13] [R14]
               rd_reg  <= rx_byte[0];
            end
            S_REG:
               ack_reg <= (rx_byte <= SCPT_TOP_ADDR);     // [R7]
            S_WDATA:
               ack_reg <= 1'b1;
            default:
               ack_reg <= 1'b0;
         endcase
      end
      else if (ev.fall && cnt_reg == SCPT_ACK_BIT)
      begin
         ack_reg <= 1'b0;
         case (state_reg)
            S_ADDR:
               if (!ack_reg)
                  state_reg <= S_WAIT;
               else if (rd_reg)
                  state_reg <= S_RDATA;                   // [R9]
               else
                  state_reg <= S_REG;                     // [R4]
            S_REG:
               state_reg <= ack_reg ? S_WDATA : S_WAIT;   // [R2]
            S_WDATA:
               state_reg <= S_WDATA;
            S_RDATA:
               state_reg <= mack_reg ? S_RDATA : S_WAIT;  // [R3]
            S_WAIT:
               state_reg <= S_WAIT;
            default:
               state_reg <= S_IDLE;
         endcase
      end
   end

   // Register pointer, held across transfers when only the address is sent
   always_ff @(posedge core_clk)
   begin
      if (reset)
         ptr_reg <= SCPT_PTR_RESET;
      else if (ev.fall && cnt_reg == 4'h7 && state_reg == S_REG
               && rx_byte <= SCPT_TOP_ADDR)
         ptr_reg <= rx_byte;                              // [R4] [R8] [R16]
      else if (ev.fall && cnt_reg == SCPT_ACK_BIT
               && (state_reg == S_WDATA || state_reg == S_RDATA))
         ptr_reg <= scpt_incr(ptr_reg);                   // [R5] [R6] [R10]
   end

   // Write strobe to the register file, one cycle per data byte
   always_ff @(posedge core_clk)
   begin
      if (reset)
         wr <= '0;
      else
      begin
         wr.we <= ev.fall && cnt_reg == 4'h7 && state_reg == S_WDATA; // [R5]
         if (ev.fall && cnt_reg == 4'h7)
         begin
            wr.addr  <= ptr_reg;
            wr.wdata <= rx_byte;
         end
      end
   end

   // Transmit shifter, loaded when a read byte begins
   always_ff @(posedge core_clk)
   begin
      if (reset)
         tx_reg <= 8'hFF;
      else if (ev.fall && cnt_reg == SCPT_ACK_BIT)
         tx_reg <= rd_data;                               // [R9] [R10]
      else if (ev.fall && cnt_reg < 4'h7)
         tx_reg <= {tx_reg[6:0], 1'b1};                   // [R1]
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         rd_addr <= SCPT_PTR_RESET;
      else
         rd_addr <= (state_reg == S_RDATA && cnt_reg == SCPT_ACK_BIT)
                    ? scpt_incr(ptr_reg) : ptr_reg;
   end

   // Pin drive: open drain, only ever pulls low.
   // The first read byte loads from ptr_reg at the address ack slot.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         sda_out <= 1'b0;
         sda_oe  <= 1'b0;
      end
      else
      begin
         sda_out <= 1'b0;
         if (ev.start || ev.stop)
            sda_oe <= 1'b0;
         else if (ev.fall)
         begin
            if (cnt_reg == 4'h7)
               sda_oe <= (state_reg != S_RDATA) && (state_reg != S_WAIT)
                         && (state_reg != S_IDLE)
                         && ((state_reg == S_ADDR)
                             ? (rx_byte[7:1] == {SCPT_ADDR_HI, sel_s})
                             : (state_reg == S_REG)
                               ? (rx_byte <= SCPT_TOP_ADDR) : 1'b1); // [R2] [R13]
            else if (cnt_reg == SCPT_ACK_BIT)
               sda_oe <= (state_reg == S_ADDR && ack_reg && rd_reg)
                         ? ~rd_data[7]
                         : (state_reg == S_RDATA && mack_reg)
                           ? ~rd_data[7] : 1'b0;          // [R3] [R1]
            else if (state_reg == S_RDATA)
               sda_oe <= ~tx_reg[6];
            else
               sda_oe <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         busy <= 1'b0;
      else
         busy <= (state_reg != S_IDLE);
   end
endmodule : scpt_slave
`default_nettype wire

// ==== common/scpt_pkg.sv ====
// Constants and carrier types for the two-wire control port slave.
// Assumes the register file sits outside and answers within one cycle.
// Behaviour
// [R1] Bytes move most significant bit first, least significant last.
// [R2] On a withheld write acknowledge the data line stays released high.
// [R3] Missing master acknowledge in a read ends data; line released high.
// [R4] First write byte after slave address loads the 8-bit base pointer.
// [R5] First data byte goes to base; pointer then advances per byte.
// [R6] Pointer stops advancing at the top register address.
// [R7] No acknowledge for a base address above the top address.
// [R8] Master sets base pointer with a write before reading.
// [R9] Reads start at the base pointer from the latest address write.
// [R10] Pointer advances by one after each byte sent in a read.
// [R11] Stop condition, data rising while clock high, ends the transfer.
// [R12] Repeated start is accepted and restarts address decoding.
// [R13] Seven address bits plus direction; acknowledge only on own address.
// [R14] Address upper six bits 100110, lowest bit from select pin.
// [R15] Start or stop returns to idle and discards any partial byte. Start goes to S_ADDR, not idle; only stop returns to S_IDLE.
// [R16] Base pointer kept after an address-only write for later reads.
package scpt_pkg;
   localparam logic [5:0] SCPT_ADDR_HI   = 6'h26;
   localparam logic [7:0] SCPT_TOP_ADDR  = 8'h2E;
   localparam logic [7:0] SCPT_PTR_RESET = 8'h00;
   localparam logic [3:0] SCPT_ACK_BIT   = 4'h8;
   localparam logic [3:0] SCPT_CNT_RESET = 4'h0;
   // Start parks the counter one below zero, so the clock fall that
   // closes the start condition wraps it to bit 0 instead of bit 1
   localparam logic [3:0] SCPT_CNT_START = 4'hF;

   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } scpt_wr_t;

   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } scpt_ev_t;

   function automatic logic [7:0] scpt_incr(input logic [7:0] p);
      if (p >= SCPT_TOP_ADDR)
         scpt_incr = SCPT_TOP_ADDR;
      else
         scpt_incr = p + 8'h01;
   endfunction : scpt_incr
endpackage : scpt_pkg

// ==== verilog/scpt_sync.sv ====
// Two-flop synchroniser for one asynchronous pin level.
// Assumes the pin is quasi-static relative to core_clk.
`timescale 1ns/1ps
`default_nettype none
module scpt_sync
(
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic din,
   output var  logic dout
);
   import scpt_pkg::*;
   logic meta_reg;

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         meta_reg <= 1'b1;
         dout     <= 1'b1;
      end
      else
      begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end
endmodule : scpt_sync
`default_nettype wire

// ==== verilog/scpt_cond.sv ====
// Bus event detector: clock edges and start/stop conditions.
// Assumes both inputs are already synchronised to core_clk.
`timescale 1ns/1ps
`default_nettype none
module scpt_cond
(
   input  wire logic               core_clk,
   input  wire logic               reset,
   input  wire logic               scl_s,
   input  wire logic               sda_s,
   output var  scpt_pkg::scpt_ev_t ev
);
   import scpt_pkg::*;
   logic scl_d_reg;
   logic sda_d_reg;

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         ev        <= '0;
      end
      else
      begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
         ev.rise   <= scl_s & ~scl_d_reg;
         ev.fall   <= ~scl_s & scl_d_reg;
         ev.start  <= scl_s & scl_d_reg & sda_d_reg & ~sda_s;
         ev.stop   <= scl_s & scl_d_reg & ~sda_d_reg & sda_s; // [R11]
      end
   end
endmodule : scpt_cond
`default_nettype wire

// ==== verif/scpt_master.sv ====
// Bus master model driving the clock and the open-drain data line.
// Assumes a pull-up on data; the bench resolves the wire.
`timescale 1ns/1ps
`default_nettype none
module scpt_master
(
   output var  logic scl,
   output var  logic oe,
   input  wire logic sda
);
   // Phase longer than the slave's answer delay after a clock fall
   localparam int P = 64;
   initial
   begin
      scl = 1'b1;
      oe = 1'b0;
   end
   // Works from idle or mid-transfer; clock stays high between frames
   task automatic t_start();
      #(P/2) oe = 1'b0;
      #(P/2) scl = 1'b1;
      #P oe = 1'b1;
      #P scl = 1'b0;
   endtask : t_start
   // Sample just before the fall, clear of core clock edges
   task automatic t_bit(input logic b, output logic r);
      #(P/2) oe = !b;
      #(P/2) scl = 1'b1;
      #(P-2) r = sda;
      #2 scl = 1'b0;
   endtask : t_bit
   task automatic t_byte(input logic [7:0] d, input logic a,
      output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--)
         t_bit(d[i], q[i]);
      t_bit(a, k);
   endtask : t_byte
   task automatic t_stop();
      #(P/2) oe = 1'b1;
      #(P/2) scl = 1'b1;
      #P oe = 1'b0;
      #P;
   endtask : t_stop
endmodule : scpt_master
`default_nettype wire

// ==== verif/scpt_slave_chk.sv ====
// Assertions on the control port slave ports.
// Assumes bus clock phases of at least eight core cycles.
`timescale 1ns/1ps
`default_nettype none
module scpt_slave_chk
(
   input wire logic               core_clk,
   input wire logic               reset,
   input wire logic               scl_in,
   input wire logic               sda_in,
   input wire logic               sda_out,
   input wire logic               sda_oe,
   input wire scpt_pkg::scpt_wr_t wr,
   input wire logic [7:0]         rd_addr,
   input wire logic               busy
);
   import scpt_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   a_drive_low: assert property (sda_oe |-> !sda_out)
      else $error("data driven high");
   a_we_single: assert property (wr.we |=> !wr.we)
      else $error("write strobe too long");
   a_we_range: assert property
      (wr.we |-> wr.addr <= SCPT_TOP_ADDR)
      else $error("write beyond top");
   a_rd_range: assert property (rd_addr <= SCPT_TOP_ADDR)
      else $error("read pointer beyond top");
   a_we_clock_low: assert property (wr.we |-> busy && !scl_in)
      else $error("write strobe outside clock low");
   a_ack_clock_low: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("data pulled while clock high");
   a_idle_released: assert property (!busy [*3] |-> !sda_oe)
      else $error("data pulled while idle");
   a_stop_idle: assert property
      (scl_in && $rose(sda_in) |-> ##[1:10] !busy)
      else $error("stop not ending transfer");
   a_start_quiet: assert property
      (scl_in && $fell(sda_in) |=> !sda_oe [*8])
      else $error("data pulled after start");
   a_reset_quiet: assert property (disable iff (1'b0)
      reset |=> !busy && !sda_oe && !wr.we)
      else $error("outputs active after reset");
endmodule : scpt_slave_chk
bind scpt_slave scpt_slave_chk chk_u (.core_clk, .reset, .scl_in,
   .sda_in, .sda_out, .sda_oe, .wr, .rd_addr, .busy);
`default_nettype wire

// ==== verif/scpt_slave_tb.sv ====
// Bench: master model, xor register file stand-in, write log.
// Assumes slave and master share one pulled-up data wire.
`timescale 1ns/1ps
`default_nettype none
module scpt_slave_tb;
   import scpt_pkg::*;
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic        sel = 1'b0;
   logic        m_scl;
   logic        m_oe;
   logic        sda_out;
   logic        sda_oe;
   logic        busy;
   logic [7:0]  rd_addr;
   scpt_wr_t    wr;
   int          fail_count = 0;
   int          total_checks = 0;
   logic [15:0] wq[$];
   logic [15:0] exq[$];
   wire logic   sda_w = !m_oe && (!sda_oe || sda_out);
   wire logic [7:0] rd_data = rd_addr ^ 8'h5A;
   scpt_slave dut_u (.core_clk(core_clk), .reset(reset), .scl_in(m_scl),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_select_pin(sel), .wr(wr), .rd_addr(rd_addr),
      .rd_data(rd_data), .busy(busy));
   scpt_master mst_u (.scl(m_scl), .oe(m_oe), .sda(sda_w));
   always #4 core_clk = !core_clk;
   always @(posedge core_clk)
      if (wr.we)
         wq.push_back({wr.addr, wr.wdata});
   function automatic logic [7:0] nx(input logic [7:0] p);
      return (p >= 8'h2E) ? 8'h2E : p + 8'h01;
   endfunction : nx
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string n, input logic [7:0] s, e);
      total_checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0)
      begin
         @(posedge core_clk);
         #1 n++;
         if (n > 20)
         begin
            fail_count++;
            tally_and_finish();
         end
      end
   endtask : wait_idle
   task automatic wr_burst(input logic [7:0] base, input int n);
      logic [7:0] q, d, p;
      logic       k;
      wq.delete();
      exq.delete();
      mst_u.t_start();
      mst_u.t_byte({6'h26, sel, 1'b0}, 1'b1, q, k);
      chk("addr_ack", k, 1'b0);
      mst_u.t_byte(base, 1'b1, q, k);
      chk("base_ack", k, base > 8'h2E);
      p = base;
      for (int i = 0; i < n; i++)
      begin
         d = 8'($urandom);
         mst_u.t_byte(d, 1'b1, q, k);
         chk("data_ack", k, base > 8'h2E);
         if (base <= 8'h2E)
            exq.push_back({p, d});
         p = nx(p);
      end
      mst_u.t_stop();
      wait_idle();
      chk("wr_count", 8'(wq.size()), 8'(exq.size()));
      foreach (exq[i])
      begin
         chk("wr_addr", wq[i][15:8], exq[i][15:8]);
         chk("wr_data", wq[i][7:0], exq[i][7:0]);
      end
   endtask : wr_burst
   task automatic rd_seq(input logic [7:0] base, input int n,
      input logic sr, input int part);
      logic [7:0] q, p;
      logic       k;
      wq.delete();
      mst_u.t_start();
      mst_u.t_byte({6'h26, sel, 1'b0}, 1'b1, q, k);
      mst_u.t_byte(base, 1'b1, q, k);
      for (int i = 0; i < part; i++)
         mst_u.t_bit(1'b0, k);
      if (!sr)
      begin
         mst_u.t_stop();
         wait_idle();
      end
      mst_u.t_start();
      mst_u.t_byte({6'h26, sel, 1'b1}, 1'b1, q, k);
      chk("rd_addr_ack", k, 1'b0);
      p = base;
      for (int i = 0; i < n; i++)
      begin
         mst_u.t_byte(8'hFF, i == n - 1, q, k);
         chk("rd_data", q, p ^ 8'h5A);
         p = nx(p);
      end
      mst_u.t_stop();
      wait_idle();
      chk("rd_no_write", 8'(wq.size()), 8'h00);
   endtask : rd_seq
   initial
   begin
      logic [7:0] q;
      logic       k;
      void'($urandom(69452));
      repeat (20) @(posedge core_clk);
      #1 reset = 1'b0;
      repeat (8) @(posedge core_clk);
      #1;
      for (int s = 0; s < 4; s++)
      begin
         sel = s[0];
         mst_u.t_start();
         mst_u.t_byte({6'h26, s[1], 1'b0}, 1'b1, q, k);
         chk("addr_match", k, s[0] != s[1]);
         mst_u.t_stop();
         wait_idle();
      end
      $display("test address match done");
      sel = 1'($urandom);
      wr_burst(8'h2C, 5);
      wr_burst(8'($urandom_range(46, 0)), $urandom_range(4, 1));
      wr_burst(8'h2F, 2);
      $display("test write bursts done");
      rd_seq(8'h2B, 5, 1'b1, 0);
      rd_seq(8'($urandom_range(46, 0)), 3, 1'b0, 0);
      rd_seq(8'h10, 1, 1'b1, 3);
      $display("test reads done");
      tally_and_finish();
   end
endmodule : scpt_slave_tb
`default_nettype wire
